/* File: design/dfl_done_flags.sv */
// module: per-channel full-length completion flag register of the dma engine
// What this block does
// - bit 7 of the flag register reads zero; writes to it are ignored.
// - bits 6 to 0 hold one completion flag, bit n for channel n.
// - flag sets when channel offset address equals transfer size minus one.
// - hardware never clears a flag; only reset or software clears it.
// - a completion raises the flag only when that channel's config bit 7 enables it.
module dfl_done_flags
  import dfl_pkg::*;
#(
  parameter int unsigned P_NUM_CHAN = dfl_pkg::NUM_CHAN,
  parameter int unsigned P_ADDR_W = dfl_pkg::ADDR_W
)
(
  input wire logic i_clk, // system clock, 125 MHz
  input wire logic i_reset_n, // asynchronous system reset, active low
  input wire dfl_pkg::dfl_sfr_req_t i_sfr_req, // sfr bus access
  output logic [7:0] o_sfr_rdata, // read data, valid the cycle after rd
  input wire logic [P_NUM_CHAN*P_ADDR_W-1:0] i_chan_offset_address, // running offsets
  input wire logic [P_NUM_CHAN*P_ADDR_W-1:0] i_chan_transfer_size, // programmed sizes
  input wire logic [P_NUM_CHAN-1:0] i_chan_config_irq_en, // bit 7 of each chan_config
  output logic [P_NUM_CHAN-1:0] o_chan_done_flag // flags towards the interrupt logic
);
  import dfl_pkg::*;

  // refuse shapes the flag byte cannot hold: the channels must sit below the unused bit
  if (P_NUM_CHAN < 1 || P_NUM_CHAN > UNUSED_BIT)
  begin : g_bad_chan_count
    $error("channel count must be 1 to 7 to fit below the unused bit");
  end

  // a zero-width offset would leave nothing to compare against the size
  if (P_ADDR_W < 1)
  begin : g_bad_addr_width
    $error("address width must be at least 1");
  end

  function automatic logic [P_ADDR_W-1:0] field(input logic [P_NUM_CHAN*P_ADDR_W-1:0] v,
                                                input int unsigned n);
    field = v[n*P_ADDR_W +: P_ADDR_W];
  endfunction

  logic [P_NUM_CHAN-1:0] flags_q;
  logic [P_NUM_CHAN-1:0] flags_d;
  logic [P_NUM_CHAN-1:0] match_q;
  logic [P_NUM_CHAN-1:0] match_now;
  logic [P_NUM_CHAN-1:0] set_pulse;
  logic [7:0] rdata_q;
  logic [7:0] flags_wide;
  wire sel = (i_sfr_req.addr == DONE_FLAGS_ADDR) && (i_sfr_req.page == DONE_FLAGS_PAGE);
  wire wr_hit = sel && i_sfr_req.wr;
  wire rd_hit = sel && i_sfr_req.rd;

  // edge on the compare so a channel parked at its last offset does not
  // keep re-asserting the flag and lock out the software clear
  genvar g;
  generate
    for (g = 0; g < P_NUM_CHAN; g++)
    begin : g_cmp
      assign match_now[g] = i_chan_config_irq_en[g] &&
        (field(i_chan_offset_address, g) ==
         P_ADDR_W'(field(i_chan_transfer_size, g) - 1'b1));
    end
  endgenerate

  assign set_pulse = match_now & ~match_q;

  // software writes store the channel bits; a hardware set is or-ed on top
  // so a clear racing a completion can never swallow that completion
  wire [P_NUM_CHAN-1:0] wr_bits = i_sfr_req.wdata[P_NUM_CHAN-1:0];
  wire [P_NUM_CHAN-1:0] kept_bits = wr_hit ? wr_bits : flags_q;
  assign flags_d = kept_bits | set_pulse;

  // bit 7 and bits above the channel count always read as zero
  assign flags_wide = 8'(flags_q) & FLAG_FIELD_MASK;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flags_q <= P_NUM_CHAN'(DONE_FLAGS_RESET);
      match_q <= '0;
      rdata_q <= 8'h00;
    end
    else
    begin
      flags_q <= flags_d;
      match_q <= match_now;
      rdata_q <= rd_hit ? flags_wide : 8'h00;
    end
  end

  assign o_sfr_rdata = rdata_q;
  assign o_chan_done_flag = flags_q;

  a_unused_bit_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_sfr_rdata[UNUSED_BIT] == 1'b0) else $error("unused bit read as one");

  a_read_returns_flags: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    rd_hit |=> o_sfr_rdata[P_NUM_CHAN-1:0] == $past(flags_q))
    else $error("read data does not match the flags");

  a_match_sets_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (match_now[0] && !match_q[0]) |=> flags_q[0]) else $error("completion did not set flag");

  a_no_hw_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (!wr_hit && flags_q[0]) |=> flags_q[0]) else $error("flag cleared without software");

  a_sw_clear_works: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (wr_hit && !i_sfr_req.wdata[0] && !set_pulse[0]) |=> !flags_q[0])
    else $error("software clear had no effect");

  a_enable_gates_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (!i_chan_config_irq_en[0] && !flags_q[0] && !(wr_hit && i_sfr_req.wdata[0])) |=> !flags_q[0])
    else $error("flag set while disabled");

  a_set_beats_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (wr_hit && !i_sfr_req.wdata[0] && set_pulse[0]) |=> flags_q[0])
    else $error("completion lost under clear");

  a_unmapped_reads_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !rd_hit |=> o_sfr_rdata == 8'h00) else $error("unselected read returned data");

  // the same guards for every channel, so a slip in one slice of the
  // per-channel logic cannot hide behind a correct channel 0
  genvar h;
  generate
    for (h = 0; h < P_NUM_CHAN; h++)
    begin : g_chan_chk

      // a rising compare always lands in the flag one cycle later
      a_chan_match_set: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (match_now[h] && !match_q[h]) |=> flags_q[h]
      ) else $error("channel flag not set by completion");

      // once set, only a software write of zero may drop the flag
      a_chan_flag_holds: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (flags_q[h] && !(wr_hit && !i_sfr_req.wdata[h])) |=> flags_q[h]
      ) else $error("channel flag cleared by hardware");

      // a plain software clear with no completion pending takes effect
      a_chan_clear_works: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_hit && !i_sfr_req.wdata[h] && !set_pulse[h]) |=> !flags_q[h]
      ) else $error("channel clear had no effect");

      // a disabled channel never raises its flag on its own
      a_chan_enable_gates: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (!i_chan_config_irq_en[h] && !flags_q[h] && !(wr_hit && i_sfr_req.wdata[h]))
          |=> !flags_q[h]
      ) else $error("channel flag set while disabled");

      // completion and clear in one cycle: the completion is kept
      a_chan_set_wins: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_hit && !i_sfr_req.wdata[h] && set_pulse[h]) |=> flags_q[h]
      ) else $error("channel completion lost under clear");

      // the flag bits are read/write, so writing one sets the flag
      a_chan_write_sets: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_hit && i_sfr_req.wdata[h]) |=> flags_q[h]
      ) else $error("channel write of one not stored");

      // nothing but a completion or a write of one may raise the flag
      a_chan_stays_clear: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        (!flags_q[h] && !set_pulse[h] && !(wr_hit && i_sfr_req.wdata[h])) |=> !flags_q[h]
      ) else $error("channel flag rose with no cause");

      // bit n of the read byte carries channel n
      a_chan_read_bit: assert property (
        @(posedge i_clk) disable iff (!i_reset_n)
        rd_hit |=> o_sfr_rdata[h] == $past(flags_q[h])
      ) else $error("channel bit misplaced in read data");
    end
  endgenerate
endmodule // dfl_done_flags

/* File: design/dfl_pkg.sv */
// package: constants and carriers for the dma channel completion flag register
package dfl_pkg;
  localparam int unsigned NUM_CHAN = 7;
  localparam int unsigned ADDR_W = 16;
  localparam logic [7:0] DONE_FLAGS_ADDR = 8'hD3;
  localparam logic [7:0] DONE_FLAGS_PAGE = 8'h02;
  localparam logic [7:0] DONE_FLAGS_RESET = 8'h00;
  localparam int unsigned UNUSED_BIT = 7;
  localparam int unsigned CFG_IRQ_EN_BIT = 7;
  localparam logic [7:0] FLAG_FIELD_MASK = 8'h7F;

  // one special-function register bus access, sampled in the cycle it is presented
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] page;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dfl_sfr_req_t;
endpackage : dfl_pkg

/* File: tb/testbench.sv */
// testbench: random and corner checks of the dma completion flag register
module testbench
  import dfl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 0, i_reset_n = 0, hit = 0;
  logic [15:0] s = 16'h0001;
  logic [6:0] en = '0;
  dfl_sfr_req_t r = '0;
  logic [7:0] o_sfr_rdata;
  logic [6:0] o_chan_done_flag;
  int error_cnt = 0, cmp_count = 0, seed = 30;
  // offsets sit at size, one above the match, until hit moves them to size minus one
  wire logic [111:0] offs = hit ? {7{s - 16'h0001}} : {7{s}};
  dfl_done_flags dfl_done_flags_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sfr_req(r),
    .o_sfr_rdata(o_sfr_rdata), .i_chan_offset_address(offs), .i_chan_transfer_size({7{s}}),
    .i_chan_config_irq_en(en), .o_chan_done_flag(o_chan_done_flag));
  initial forever #4 i_clk = ~i_clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d, input logic h);
    @(posedge i_clk);
    r <= '{a, DONE_FLAGS_PAGE, w, !w, d};
    hit <= h;
    @(posedge i_clk);
    r <= '0;
    hit <= 1'b0;
    #1;
  endtask
  function automatic logic [7:0] flag_byte(input logic [6:0] f);
    return {1'b0, f};
  endfunction
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // each pass needs about fifteen cycles, so this leaves a wide margin
  initial
  begin
    #10us;
    error_cnt++;
    results();
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    acc(1'b0, DONE_FLAGS_ADDR, 8'h00, 1'b0);
    chk(o_sfr_rdata, DONE_FLAGS_RESET);
    for (int k = 0; k < 6; k++)
    begin
      @(posedge i_clk);
      s <= 16'($random(seed));
      en <= (k == 0) ? 7'h7F : (k == 1) ? 7'h00 : 7'($random(seed));
      acc(1'b0, 8'hD4, 8'h00, 1'b1);
      chk(o_sfr_rdata, 8'h00);
      chk({1'b0, o_chan_done_flag}, {1'b0, en});
      acc(1'b0, DONE_FLAGS_ADDR, 8'h00, 1'b0);
      chk(o_sfr_rdata, flag_byte(en));
      acc(1'b1, 8'hD4, 8'hFF, 1'b0);
      chk({1'b0, o_chan_done_flag}, {1'b0, en});
      acc(1'b1, DONE_FLAGS_ADDR, 8'hFF, 1'b0);
      acc(1'b0, DONE_FLAGS_ADDR, 8'h00, 1'b0);
      chk(o_sfr_rdata, FLAG_FIELD_MASK);
      acc(1'b1, DONE_FLAGS_ADDR, 8'h00, 1'b1);
      chk({1'b0, o_chan_done_flag}, {1'b0, en});
      acc(1'b1, DONE_FLAGS_ADDR, 8'h00, 1'b0);
      chk({1'b0, o_chan_done_flag}, 8'h00);
      $display("test %0d done", k);
    end
    acc(1'b1, DONE_FLAGS_ADDR, 8'hFF, 1'b0);
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    acc(1'b0, DONE_FLAGS_ADDR, 8'h00, 1'b0);
    chk(o_sfr_rdata, DONE_FLAGS_RESET);
    chk(flag_byte(o_chan_done_flag), 8'h00);
    $display("test reset done");
    results();
  end
endmodule // testbench
